// >>> design/dflr_pkg.sv
// package: constants and carriers of the decode front end with loop replay
package dflr_pkg;

  // ---------------------------------------------------------------
  // loop replay limits
  // ---------------------------------------------------------------
  localparam logic [2:0] LOOP_MAX_FETCH_BLOCKS = 3'h4;
  localparam logic [4:0] FETCH_BLOCK_BYTES     = 5'h10;
  localparam logic [4:0] LOOP_MAX_INSNS        = 5'h12;
  localparam logic [2:0] LOOP_MAX_TAKEN        = 3'h4;

  // ---------------------------------------------------------------
  // decoder limits
  // ---------------------------------------------------------------
  localparam logic [3:0] MAX_INSN_BYTES        = 4'hf;
  localparam logic [3:0] FIRST_DEC_MAX_UOPS    = 4'h4;
  localparam logic [3:0] SIMPLE_DEC_MAX_BYTES  = 4'h7;
  localparam logic [3:0] SIMPLE_DEC_MAX_UOPS   = 4'h1;
  localparam logic [3:0] ROM_SETUP_UOPS        = 4'h4;
  localparam logic [1:0] MULTI_PREFIX_EXTRA    = 2'h1;
  localparam int         UOP_W                 = 8;
  localparam int         FIFO_DEPTH            = 4;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0]  len;       // bytes without prefixes
    logic [2:0]  prefixes;  // number of prefixes
    logic [3:0]  uops;      // micro-op count
    logic        complex;   // needs the microcode rom
    logic        taken_br;  // taken branch
    logic        is_ret;    // subroutine return
    logic        loop_end;  // backward branch closing a loop
    logic [3:0]  blk_off;   // byte offset within its fetch block
    logic [UOP_W-1:0] tag;  // opaque payload
  } dflr_insn_s;

  typedef struct packed {
    logic [1:0]       slot;    // decoder that produced it
    logic             rom;     // from the microcode rom
    logic             replay;  // came from loop replay
    logic [UOP_W-1:0] tag;
  } dflr_uop_s;

  localparam int INSN_W = $bits(dflr_insn_s);
  localparam int UOPS_W = $bits(dflr_uop_s);

  typedef enum logic {
    DFLR_MODE_SINGLE,
    DFLR_MODE_TRIPLE
  } dflr_mode_e;

endpackage : dflr_pkg

// >>> design/dflr_fifo.sv
// file: small valid/ready fifo with registered read data
`timescale 1ns/100ps
`default_nettype none
module dflr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             rst_i,
  // write side
  input  wire logic             wr_valid_i,
  output logic                  wr_ready_o,
  input  wire logic [WIDTH-1:0] wr_data_i,
  // read side
  output logic                  rd_valid_o,
  input  wire logic             rd_ready_i,
  output logic [WIDTH-1:0]      rd_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]      cnt_r, cnt_nxt;
  logic [WIDTH-1:0] dout_r, dout_nxt;
  logic             dv_r, dv_nxt;
  logic             push, pop, load;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    push    = wr_valid_i && (cnt_r != AW'(0) + (AW+1)'(DEPTH));
    load    = (cnt_r != '0) && (!dv_r || rd_ready_i);
    pop     = load;
    wp_nxt  = push ? AW'(wp_r + 1'b1) : wp_r;
    rp_nxt  = pop ? AW'(rp_r + 1'b1) : rp_r;
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    dout_nxt = load ? mem_r[rp_r] : dout_r;
    dv_nxt   = load ? 1'b1 : (rd_ready_i ? 1'b0 : dv_r);
  end

  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem_r[wp_r] <= wr_data_i;
    end
    if (rst_i) begin
      wp_r   <= '0;
      rp_r   <= '0;
      cnt_r  <= '0;
      dv_r   <= 1'b0;
      dout_r <= '0;
    end else begin
      wp_r   <= wp_nxt;
      rp_r   <= rp_nxt;
      cnt_r  <= cnt_nxt;
      dv_r   <= dv_nxt;
      dout_r <= dout_nxt;
    end
  end

  assign wr_ready_o = (cnt_r != (AW+1)'(DEPTH));
  assign rd_valid_o = dv_r;
  assign rd_data_o  = dout_r;

endmodule : dflr_fifo
`default_nettype wire

// >>> design/dflr_front_end.sv
// file: decode front end with loop replay detector and decoder steering
// ---------------------------------------------------------------
// Notes on behaviour
// - replay only loops spanning at most four 16-byte fetch blocks.
// - loops holding more than 18 instructions are never replayed.
// - at most four taken branches, none a subroutine return.
// - every replayed loop ends in a mispredicted exit to recover from.
// - single-decoder mode decodes at most one instruction per cycle.
// - single-decoder complex instructions take micro-ops from the rom.
// - single-decoder mode applies no alignment constraints to steering.
// - first decoder takes one instruction of up to four uops, 15 bytes.
// - other two decoders take only one-uop instructions of seven bytes.
// - more than four uops keeps the decoder busy several cycles.
// - multi-prefix instructions go only to the first decoder, one extra cycle in three-decoder mode.
// - each prefix counts as one byte of length for steering.
// - single-decoder rom dispatch costs four setup micro-ops.
// - in three-decoder mode multi-prefix instructions stall one cycle before their micro-ops leave.
// ---------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none
module dflr_front_end (
  // clock and reset
  input  wire logic                       sys_clk_i,
  input  wire logic                       rst_i,
  // configuration
  input  wire dflr_pkg::dflr_mode_e       mode_i,
  // instruction stream from fetch
  input  wire logic                       in_valid_i,
  output logic                            in_ready_o,
  input  wire dflr_pkg::dflr_insn_s       in_insn_i,
  // exit branch resolution from the core
  input  wire logic                       exit_mispred_i,
  // micro-ops toward rename
  output logic                            uop_valid_o,
  input  wire logic                       uop_ready_i,
  output dflr_pkg::dflr_uop_s             uop_o,
  // status
  output logic                            replay_active_o,
  output logic                            recover_o
);
  typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_EMIT} dflr_dec_state_e;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // length as the steering logic sees it: every prefix adds a byte
  function automatic logic [4:0] eff_len(input dflr_pkg::dflr_insn_s i);
    eff_len = 5'(i.len) + 5'(i.prefixes);
  endfunction : eff_len

  function automatic logic multi_prefix(input dflr_pkg::dflr_insn_s i);
    multi_prefix = (i.prefixes > 3'h1);
  endfunction : multi_prefix

  function automatic logic fits_simple(input dflr_pkg::dflr_insn_s i);
    fits_simple = (i.uops == dflr_pkg::SIMPLE_DEC_MAX_UOPS)
               && (eff_len(i) <= 5'(dflr_pkg::SIMPLE_DEC_MAX_BYTES))
               && !multi_prefix(i) && !i.complex;
  endfunction : fits_simple

  // an instruction that reports no micro-ops still issues one
  function automatic logic [3:0] uop_base(input dflr_pkg::dflr_insn_s i);
    uop_base = (i.uops == 4'h0) ? 4'h1 : i.uops;
  endfunction : uop_base

  // the closing branch is taken whenever the loop repeats
  function automatic logic is_taken(input dflr_pkg::dflr_insn_s i);
    is_taken = i.taken_br || i.loop_end;
  endfunction : is_taken

  function automatic logic ret_taken(input dflr_pkg::dflr_insn_s i);
    ret_taken = is_taken(i) && i.is_ret;
  endfunction : ret_taken

  // counters stick at all ones so a long body cannot wrap back into range
  function automatic logic [2:0] sat_inc3(input logic [2:0] v);
    sat_inc3 = (v == 3'h7) ? v : v + 3'h1;
  endfunction : sat_inc3

  function automatic logic [4:0] sat_inc5(input logic [4:0] v);
    sat_inc5 = (v == 5'h1f) ? v : v + 5'h01;
  endfunction : sat_inc5

  function automatic logic loop_fits(input logic [4:0] n_insn, input logic [2:0] n_taken,
    input logic [2:0] n_blk);
    loop_fits = (n_insn <= dflr_pkg::LOOP_MAX_INSNS)
             && (n_taken <= dflr_pkg::LOOP_MAX_TAKEN)
             && (n_blk <= dflr_pkg::LOOP_MAX_FETCH_BLOCKS);
  endfunction : loop_fits

  // ---------------------------------------------------------------
  // loop replay detector
  // ---------------------------------------------------------------
  logic [4:0] lp_insns_r, lp_insns_nxt;
  logic [2:0] lp_taken_r, lp_taken_nxt;
  logic [2:0] lp_blks_r, lp_blks_nxt;
  logic       lp_bad_r, lp_bad_nxt;
  logic       rp_act_r, rp_act_nxt;
  logic       rec_r, rec_nxt;
  logic       accept;

  always_comb begin
    lp_insns_nxt = lp_insns_r;
    lp_taken_nxt = lp_taken_r;
    lp_blks_nxt  = lp_blks_r;
    lp_bad_nxt   = lp_bad_r;
    rp_act_nxt   = rp_act_r;
    rec_nxt      = 1'b0;
    if (exit_mispred_i && rp_act_r) begin
      // the exit always mispredicts: stop replay and hand back to fetch
      rp_act_nxt   = 1'b0;
      rec_nxt      = 1'b1;
      lp_insns_nxt = '0;
      lp_taken_nxt = '0;
      lp_blks_nxt  = '0;
      lp_bad_nxt   = 1'b0;
    end else if (accept && !rp_act_r) begin
      lp_insns_nxt = sat_inc5(lp_insns_r);
      if (is_taken(in_insn_i)) begin
        lp_taken_nxt = sat_inc3(lp_taken_r);
      end
      // a new fetch block starts at offset zero; the first one always counts
      if (in_insn_i.blk_off == 4'h0 || lp_blks_r == 3'h0) begin
        lp_blks_nxt = sat_inc3(lp_blks_r);
      end
      if (ret_taken(in_insn_i)) begin
        lp_bad_nxt = 1'b1;
      end
      if (in_insn_i.loop_end) begin
        rp_act_nxt   = !lp_bad_nxt && loop_fits(lp_insns_nxt, lp_taken_nxt, lp_blks_nxt);
        lp_insns_nxt = '0;
        lp_taken_nxt = '0;
        lp_blks_nxt  = '0;
        lp_bad_nxt   = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      lp_insns_r <= '0;
      lp_taken_r <= '0;
      lp_blks_r  <= '0;
      lp_bad_r   <= 1'b0;
      rp_act_r   <= 1'b0;
      rec_r      <= 1'b0;
    end else begin
      lp_insns_r <= lp_insns_nxt;
      lp_taken_r <= lp_taken_nxt;
      lp_blks_r  <= lp_blks_nxt;
      lp_bad_r   <= lp_bad_nxt;
      rp_act_r   <= rp_act_nxt;
      rec_r      <= rec_nxt;
    end
  end

  // ---------------------------------------------------------------
  // decoder steering and issue
  // ---------------------------------------------------------------
  dflr_dec_state_e    st_r, st_nxt;
  dflr_pkg::dflr_insn_s cur_r, cur_nxt;
  logic [3:0]         left_r, left_nxt;   // micro-ops still to emit
  logic [1:0]         stall_r, stall_nxt; // prefix stall cycles
  logic [1:0]         slot_r, slot_nxt;
  logic               rom_r, rom_nxt;
  logic               fifo_ready, push;
  dflr_pkg::dflr_uop_s push_uop;
  logic               in_rdy_r, in_rdy_nxt;

  // ---------------------------------------------------------------
  // decode plan for the instruction on offer, chosen by mode
  // ---------------------------------------------------------------
  logic [1:0] dec_slot;
  logic       dec_rom;
  logic [3:0] dec_left;
  logic [1:0] dec_stall;

  always_comb begin
    dec_slot  = 2'h0;
    dec_rom   = 1'b0;
    dec_left  = uop_base(in_insn_i);
    dec_stall = 2'h0;
    if (mode_i == dflr_pkg::DFLR_MODE_SINGLE) begin
      // one decoder, no alignment or length limits on steering
      dec_rom = in_insn_i.complex;
      if (in_insn_i.complex) begin
        dec_left = 4'(uop_base(in_insn_i) + dflr_pkg::ROM_SETUP_UOPS);
      end
    end else begin
      // long instructions stay on the first decoder one uop a cycle
      dec_rom = (in_insn_i.uops > dflr_pkg::FIRST_DEC_MAX_UOPS);
      if (fits_simple(in_insn_i)) begin
        // rotate simple instructions over the two extra decoders
        dec_slot = (slot_r == 2'h1) ? 2'h2 : 2'h1;
      end else begin
        dec_slot = 2'h0;
      end
      if (multi_prefix(in_insn_i)) begin
        dec_stall = dflr_pkg::MULTI_PREFIX_EXTRA;
      end
    end
  end

  always_comb begin
    st_nxt    = st_r;
    cur_nxt   = cur_r;
    left_nxt  = left_r;
    stall_nxt = stall_r;
    slot_nxt  = slot_r;
    rom_nxt   = rom_r;
    accept    = 1'b0;
    push      = 1'b0;
    push_uop  = '{slot: slot_r, rom: rom_r, replay: rp_act_r, tag: cur_r.tag};
    unique case (st_r)
      ST_IDLE: begin
        if (in_valid_i && in_rdy_r) begin
          accept    = 1'b1;
          cur_nxt   = in_insn_i;
          slot_nxt  = dec_slot;
          rom_nxt   = dec_rom;
          left_nxt  = dec_left;
          stall_nxt = dec_stall;
          st_nxt    = ST_BUSY;
        end
      end
      ST_BUSY: begin
        if (stall_r != 2'h0) begin
          stall_nxt = stall_r - 2'h1;
        end else begin
          st_nxt = ST_EMIT;
        end
      end
      ST_EMIT: begin
        // a full output buffer simply holds the issue here
        if (fifo_ready) begin
          push = 1'b1;
          left_nxt = left_r - 4'h1;
          if (left_r == 4'h1) begin
            st_nxt = ST_IDLE;
          end
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st_r    <= ST_IDLE;
      cur_r   <= '0;
      left_r  <= '0;
      stall_r <= '0;
      slot_r  <= '0;
      rom_r   <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      cur_r   <= cur_nxt;
      left_r  <= left_nxt;
      stall_r <= stall_nxt;
      slot_r  <= slot_nxt;
      rom_r   <= rom_nxt;
    end
  end

  // ---------------------------------------------------------------
  // output buffer
  // ---------------------------------------------------------------
  logic [dflr_pkg::UOPS_W-1:0] fifo_out;

  dflr_fifo #(
    .WIDTH(dflr_pkg::UOPS_W),
    .DEPTH(dflr_pkg::FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i  (sys_clk_i),
    .rst_i      (rst_i),
    .wr_valid_i (push),
    .wr_ready_o (fifo_ready),
    .wr_data_i  (push_uop),
    .rd_valid_o (uop_valid_o),
    .rd_ready_i (uop_ready_i),
    .rd_data_o  (fifo_out)
  );

  always_comb begin
    uop_o = dflr_pkg::dflr_uop_s'(fifo_out);
  end

  // ready is registered so the fetch side sees a clean level
  always_comb begin
    in_rdy_nxt = (st_nxt == ST_IDLE);
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      in_rdy_r <= 1'b0;
    end else begin
      in_rdy_r <= in_rdy_nxt;
    end
  end

  assign in_ready_o      = in_rdy_r;
  assign replay_active_o = rp_act_r;
  assign recover_o       = rec_r;

endmodule : dflr_front_end
`default_nettype wire

// >>> testbench/dflr_front_end_properties.sv
// checker: port timing of the decode front end
`timescale 1ns/100ps
`default_nettype none
module dflr_front_end_properties (
  // clock and reset
  input wire logic                 sys_clk_i,
  input wire logic                 rst_i,
  // watched ports
  input wire dflr_pkg::dflr_mode_e mode_i,
  input wire logic                 in_valid_i,
  input wire logic                 in_ready_o,
  input wire dflr_pkg::dflr_insn_s in_insn_i,
  input wire logic                 exit_mispred_i,
  input wire logic                 uop_valid_o,
  input wire logic                 uop_ready_i,
  input wire dflr_pkg::dflr_uop_s  uop_o,
  input wire logic                 replay_active_o,
  input wire logic                 recover_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  logic take;
  assign take = in_valid_i && in_ready_o;
  a_take_busy: assert property (take |=> !in_ready_o [*2])
    else $error("ready back early");
  a_prefix_stall: assert property (take && in_insn_i.prefixes > 3'h1 |=> !in_ready_o [*3])
    else $error("no prefix stall");
  a_rom_setup: assert property (take && mode_i == dflr_pkg::DFLR_MODE_SINGLE
    && in_insn_i.complex |=> !in_ready_o [*6])
    else $error("rom setup too short");
  a_long_busy: assert property (take && mode_i == dflr_pkg::DFLR_MODE_TRIPLE
    && in_insn_i.uops > 4'h4 |=> !in_ready_o [*6])
    else $error("long insn done early");
  a_extra_slot: assert property (uop_valid_o && uop_o.slot != 2'h0
    |-> !uop_o.rom && uop_o.slot != 2'h3)
    else $error("bad extra decoder uop");
  a_replay_cause: assert property ($rose(replay_active_o)
    |-> $past(take && in_insn_i.loop_end))
    else $error("replay without loop end");
  a_ret_reject: assert property (take && in_insn_i.loop_end && in_insn_i.is_ret
    && !replay_active_o |=> !replay_active_o)
    else $error("return loop replayed");
  a_replay_stop: assert property (replay_active_o && exit_mispred_i
    |=> !replay_active_o && recover_o)
    else $error("replay not ended");
  a_recover_why: assert property (recover_o
    |-> $past(replay_active_o && exit_mispred_i))
    else $error("stray recover");
  a_recover_pulse: assert property (recover_o |=> !recover_o)
    else $error("recover too long");
  cover property (take && in_insn_i.loop_end);
  cover property (recover_o);
  cover property (uop_valid_o && !uop_ready_i && !in_ready_o);
endmodule : dflr_front_end_properties
bind dflr_front_end dflr_front_end_properties dflr_front_end_properties_inst (
  .sys_clk_i, .rst_i, .mode_i, .in_valid_i, .in_ready_o, .in_insn_i, .exit_mispred_i,
  .uop_valid_o, .uop_ready_i, .uop_o, .replay_active_o, .recover_o);
`default_nettype wire

// >>> testbench/dflr_core_model.sv
// far side model: rename stage taking micro-ops with a stall pattern
`timescale 1ns/100ps
`default_nettype none
module dflr_core_model (
  // clock
  input  wire logic                sys_clk_i,
  // micro-op stream
  input  wire logic                uop_valid_i,
  output logic                     uop_ready_o,
  input  wire dflr_pkg::dflr_uop_s uop_i,
  // stall: 0 none, 1 every other cycle, 2 full
  input  wire logic [1:0]          stall_i
);
  dflr_pkg::dflr_uop_s got_q[$];
  logic                ph_r = 1'b0;
  always @(negedge sys_clk_i) begin
    ph_r <= ~ph_r;
    uop_ready_o <= (stall_i == 2'h0) || (stall_i == 2'h1 && ph_r);
  end
  always @(posedge sys_clk_i) begin
    if (uop_valid_i && uop_ready_o) got_q.push_back(uop_i);
  end
endmodule : dflr_core_model
`default_nettype wire

// >>> testbench/test_dflr_front_end.sv
// testbench: decode front end with loop replay
`timescale 1ns/100ps
`default_nettype none
module test_dflr_front_end;
  logic                 sys_clk_i = 1'b0;
  logic                 rst_i = 1'b1;
  dflr_pkg::dflr_mode_e mode_i = dflr_pkg::DFLR_MODE_TRIPLE;
  logic                 in_valid_i = 1'b0;
  logic                 in_ready_o;
  dflr_pkg::dflr_insn_s in_insn_i = '0;
  logic                 exit_mispred_i = 1'b0;
  logic                 uop_valid_o, uop_ready_i, replay_active_o, recover_o;
  dflr_pkg::dflr_uop_s  uop_o;
  logic [1:0]           stall = 2'h0;
  int                   miscompares = 0;
  int                   cmp_count = 0;
  dflr_front_end dflr_front_end_inst (.sys_clk_i, .rst_i, .mode_i, .in_valid_i,
    .in_ready_o, .in_insn_i, .exit_mispred_i, .uop_valid_o, .uop_ready_i, .uop_o,
    .replay_active_o, .recover_o);
  dflr_core_model dflr_core_model_inst (.sys_clk_i, .uop_valid_i(uop_valid_o),
    .uop_ready_o(uop_ready_i), .uop_i(uop_o), .stall_i(stall));
  initial forever #5 sys_clk_i = ~sys_clk_i;
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("miscompares %0d compares %0d", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  task automatic give_up(input string m);
    chk(8'h0, 8'h1, m);
    report_and_stop();
  endtask : give_up
  function automatic dflr_pkg::dflr_insn_s mk(input logic [3:0] ln, input logic [2:0] pf,
    input logic [3:0] up, input logic cx);
    mk = '{ln, pf, up, cx, 1'b0, 1'b0, 1'b0, 4'h1, {ln, up}};
  endfunction : mk
  task automatic send(input dflr_pkg::dflr_insn_s x);
    int n;
    n = 0;
    @(negedge sys_clk_i);
    in_valid_i = 1'b1;
    in_insn_i = x;
    while (in_ready_o !== 1'b1) begin
      n++;
      if (n > 80) give_up("not ready");
      @(negedge sys_clk_i);
    end
    @(negedge sys_clk_i);
    in_valid_i = 1'b0;
  endtask : send
  task automatic drain(input int n);
    int k;
    k = 0;
    while (dflr_core_model_inst.got_q.size() < n) begin
      k++;
      if (k > 200) give_up("uops missing");
      @(negedge sys_clk_i);
    end
    repeat (4) @(negedge sys_clk_i);
    chk(8'(dflr_core_model_inst.got_q.size()), 8'(n), "uop count");
  endtask : drain
  task automatic run(input dflr_pkg::dflr_insn_s x, input int n, input logic s0, rm);
    dflr_core_model_inst.got_q.delete();
    send(x);
    drain(n);
    foreach (dflr_core_model_inst.got_q[j]) begin
      chk(dflr_core_model_inst.got_q[j].slot == 2'h0, s0, "slot");
      chk(dflr_core_model_inst.got_q[j].rom, rm, "rom");
      chk(dflr_core_model_inst.got_q[j].tag, x.tag, "tag");
      chk(dflr_core_model_inst.got_q[j].replay, 1'b0, "replay mark");
    end
  endtask : run
  task automatic loop(input int n, b, t, input logic r, ex);
    logic l;
    for (int i = 0; i < n; i++) begin
      l = (i == n - 1);
      send('{4'h1, 3'h0, 4'h1, 1'b0, l || (i % 2 == 1 && i < 2 * (t - 1)), r && l, l,
        (i > 0 && i % 2 == 0 && i < 2 * b) ? 4'h0 : 4'h1, 8'(i)});
    end
    @(negedge sys_clk_i);
    chk(replay_active_o, ex, "replay state");
    exit_mispred_i = 1'b1;
    @(negedge sys_clk_i);
    exit_mispred_i = 1'b0;
    chk(recover_o, ex, "recover pulse");
    chk(replay_active_o, 1'b0, "replay left on");
    @(negedge sys_clk_i);
    chk(recover_o, 1'b0, "recover stuck");
    dflr_core_model_inst.got_q.delete();
  endtask : loop
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_steer;
    stall = 2'h1;
    run(mk(4'h7, 3'h0, 4'h1, 1'b0), 1, 1'b0, 1'b0);
    run(mk(4'h6, 3'h1, 4'h1, 1'b0), 1, 1'b0, 1'b0);
    run(mk(4'h7, 3'h1, 4'h1, 1'b0), 1, 1'b1, 1'b0);
    run(mk(4'h2, 3'h0, 4'h2, 1'b0), 2, 1'b1, 1'b0);
    run(mk(4'h3, 3'h2, 4'h1, 1'b0), 1, 1'b1, 1'b0);
    run(mk(4'hf, 3'h0, 4'h4, 1'b0), 4, 1'b1, 1'b0);
    stall = 2'h0;
  endtask : t_steer
  task automatic t_single;
    mode_i = dflr_pkg::DFLR_MODE_SINGLE;
    run(mk(4'h5, 3'h0, 4'h2, 1'b1), 6, 1'b1, 1'b1);
    run(mk(4'h7, 3'h0, 4'h1, 1'b0), 1, 1'b1, 1'b0);
    mode_i = dflr_pkg::DFLR_MODE_TRIPLE;
  endtask : t_single
  task automatic t_fill;
    dflr_core_model_inst.got_q.delete();
    stall = 2'h2;
    send(mk(4'h4, 3'h0, 4'h6, 1'b0));
    repeat (12) @(negedge sys_clk_i);
    chk(in_ready_o, 1'b0, "fifo full refused");
    chk(uop_valid_o, 1'b1, "uop not held");
    stall = 2'h0;
    drain(6);
  endtask : t_fill
  task automatic t_loops;
    loop(2, 1, 1, 1'b1, 1'b0);
    loop(19, 1, 1, 1'b0, 1'b0);
    loop(18, 5, 1, 1'b0, 1'b0);
    loop(18, 4, 5, 1'b0, 1'b0);
    loop(18, 4, 4, 1'b0, 1'b1);
    loop(3, 1, 1, 1'b0, 1'b1);
  endtask : t_loops
  initial begin
    repeat (3) @(negedge sys_clk_i);
    rst_i = 1'b0;
    t_steer();
    t_single();
    t_fill();
    t_loops();
    report_and_stop();
  end
endmodule : test_dflr_front_end
`default_nettype wire
